// ===== bench/pfac_tool_model.sv
// Behavioural programming tool on the serial link pins of the access control block.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/100ps
`default_nettype none
module pfac_tool_model (
	input  wire logic ref_clk,
	output logic      sclk,
	output logic      sdata,
	output logic      rst_low
);
	// The clock stands still low outside frames
	initial begin
		sclk = 1'b0;
		sdata = 1'b1;
		rst_low = 1'b0;
	end

	// Data settles a cycle before the rise, so the low gap is always met
	task automatic clk_bit(input logic b);
		@(posedge ref_clk);
		#1;
		sdata = b;
		@(posedge ref_clk);
		#1;
		sclk = 1'b1;
		@(posedge ref_clk);
		#1;
		sclk = 1'b0;
	endtask : clk_bit

	task automatic entry(input int n);
		rst_low = 1'b1;
		repeat (n) clk_bit(1'b1);
		@(posedge ref_clk);
		#1;
		rst_low = 1'b0;
		sdata = 1'b0;
	endtask : entry

	task automatic send_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) clk_bit(v[i]);
		// Released data line shows the inverse so a stale bit cannot pass
		sdata = ~v[0];
	endtask : send_byte
endmodule : pfac_tool_model
`default_nettype wire

// ===== bench/pfac_top_tb.sv
// Self-checking bench for the program flash mode access control top.
// Assumes the tool model drives the serial link pins and reset pin state.
`timescale 1ns/100ps
`default_nettype none
module pfac_top_tb
	import pfac_pkg::*;
;
	logic        ref_clk, nrst, socket_strap, test_sel, sclk_app_out, sclk_app_oe;
	logic        opt_read_protect, opt_write_protect, self_prog_req, pc_in_sec0;
	logic        req_valid, req_erase;
	logic [1:0]  opt_sec0_size, req_target;
	logic [12:0] req_addr;
	logic [5:0]  req_len;
	wire logic   reset_pin_low, sclk_in, sdata_in;
	logic        op_go_ff, op_erase_ff, op_sector_ff, op_reject_ff, boot_sys_vec_ff;
	logic        ram_we_ff, ram_exec_ff, read_block_ff, sclk_out_ff, sclk_oe_ff, sclk_pullup_ff;
	logic [1:0]  op_target_ff;
	logic [12:0] op_addr_ff;
	logic [5:0]  op_len_ff;
	logic [2:0]  mode_ff;
	logic [8:0]  ram_addr_ff;
	logic [7:0]  ram_data_ff;
	logic [8:0]  wr_addr[$];
	logic [7:0]  wr_data[$];
	int          n_mismatch, check_count;

	pfac_top u_dut (.ref_clk, .nrst, .socket_strap, .reset_pin_low, .test_sel, .sclk_in,
		.sdata_in, .sclk_app_out, .sclk_app_oe, .opt_sec0_size, .opt_read_protect,
		.opt_write_protect, .self_prog_req, .pc_in_sec0, .req_valid, .req_erase, .req_target,
		.req_addr, .req_len, .op_go_ff, .op_erase_ff, .op_target_ff, .op_sector_ff,
		.op_addr_ff, .op_len_ff, .op_reject_ff, .mode_ff, .boot_sys_vec_ff, .ram_we_ff,
		.ram_addr_ff, .ram_data_ff, .ram_exec_ff, .read_block_ff, .sclk_out_ff, .sclk_oe_ff,
		.sclk_pullup_ff);

	pfac_tool_model u_tool (.ref_clk(ref_clk), .sclk(sclk_in), .sdata(sdata_in),
		.rst_low(reset_pin_low));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Sampled mid-cycle, where the write strobe and its address have settled
	always @(negedge ref_clk) begin
		if (ram_we_ff === 1'b1) begin
			wr_addr.push_back(ram_addr_ff);
			wr_data.push_back(ram_data_ff);
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic do_reset(input logic strap);
		tick(1);
		nrst = 1'b0;
		socket_strap = strap;
		opt_sec0_size = 2'h0;
		tick(10);
		chk(read_block_ff, 1'b1);
		chk(sclk_pullup_ff, 1'b1);
		chk(sclk_oe_ff, 1'b0);
		chk(op_go_ff, 1'b0);
		chk(mode_ff, 3'h0);
		nrst = 1'b1;
		tick(6);
		wr_addr.delete();
		wr_data.delete();
	endtask : do_reset

	task automatic req(input logic er, input logic [1:0] tg, input logic [12:0] ad,
		input logic [5:0] ln, input logic go, input logic sec);
		req_valid = 1'b1;
		req_erase = er;
		req_target = tg;
		req_addr = ad;
		req_len = ln;
		tick(1);
		req_valid = 1'b0;
		chk(op_go_ff, go);
		chk(op_reject_ff, !go);
		if (go) begin
			chk(op_sector_ff, sec);
			chk(op_target_ff, tg);
			chk(op_addr_ff, ad);
			chk(op_len_ff, ln);
			chk(op_erase_ff, er);
		end
		tick(1);
		chk(op_go_ff, 1'b0);
	endtask : req

	task automatic t_user();
		do_reset(1'b0);
		req(1'b0, 2'h0, 13'h0300, 6'h01, 1'b0, 1'b0);
		sclk_app_out = 1'b1;
		sclk_app_oe = 1'b1;
		tick(2);
		chk(sclk_oe_ff, 1'b1);
		chk(sclk_out_ff, 1'b1);
		u_tool.entry(3);
		tick(4);
		chk(mode_ff, 3'h0);
	endtask : t_user

	task automatic t_socket();
		logic [12:0] lim;
		do_reset(1'b1);
		chk(mode_ff, 3'h1);
		req(1'b0, 2'h1, 13'h0000, 6'h01, 1'b1, 1'b0);
		req(1'b1, 2'h2, 13'h0010, MAX_GROUP, 1'b1, 1'b0);
		req(1'b0, 2'h0, 13'h0000, 6'h21, 1'b0, 1'b0);
		req(1'b0, 2'h0, 13'h0000, 6'h00, 1'b0, 1'b0);
		req(1'b0, 2'h3, 13'h0000, 6'h01, 1'b0, 1'b0);
		for (int s = 0; s < 4; s++) begin
			opt_sec0_size = 2'(s);
			tick(1);
			lim = 13'h0200 << s;
			req(1'b1, 2'h0, lim - 13'h0001, 6'h01, 1'b1, 1'b0);
			req(1'b0, 2'h0, lim, MAX_GROUP, 1'b1, 1'b1);
		end
		opt_read_protect = 1'b1;
		tick(2);
		chk(read_block_ff, 1'b1);
		req(1'b0, 2'h0, 13'h1000, 6'h01, 1'b0, 1'b0);
		req(1'b0, 2'h1, 13'h0000, 6'h01, 1'b1, 1'b0);
		opt_read_protect = 1'b0;
		tick(2);
		chk(read_block_ff, 1'b0);
	endtask : t_socket

	task automatic t_link(input logic t, input int n);
		do_reset(1'b0);
		test_sel = t;
		u_tool.entry(4);
		tick(3);
		chk(mode_ff, t ? 3'h3 : 3'h2);
		chk(boot_sys_vec_ff, 1'b1);
		chk(sclk_oe_ff, 1'b0);
		u_tool.send_byte(8'(n));
		for (int i = 0; i < n; i++) u_tool.send_byte(8'hA5 ^ 8'(i));
		tick(4);
		chk(16'(wr_addr.size()), 16'(n));
		for (int i = 0; i < n && i < wr_addr.size(); i++) begin
			chk(wr_addr[i], RAM_LOAD_BASE + 9'(i));
			chk(wr_data[i], 8'hA5 ^ 8'(i));
		end
		chk(ram_exec_ff, 1'b1);
		req(1'b0, 2'h0, 13'h0010, 6'h01, !t, 1'b0);
		req(1'b1, 2'h0, 13'h0400, 6'h01, !t, 1'b1);
		req(1'b0, 2'h1, 13'h0000, 6'h01, !t, 1'b0);
		req(1'b1, 2'h2, 13'h0020, MAX_GROUP, !t, 1'b0);
	endtask : t_link

	task automatic t_self();
		do_reset(1'b0);
		self_prog_req = 1'b1;
		pc_in_sec0 = 1'b1;
		for (int i = 0; i < 10 && mode_ff !== 3'h4; i++) tick(1);
		chk(mode_ff, 3'h4);
		req(1'b0, 2'h0, 13'h0010, 6'h01, 1'b0, 1'b0);
		req(1'b0, 2'h1, 13'h0000, 6'h01, 1'b0, 1'b0);
		req(1'b1, 2'h0, 13'h0400, 6'h01, 1'b1, 1'b1);
		req(1'b0, 2'h2, 13'h0000, 6'h01, 1'b1, 1'b0);
		pc_in_sec0 = 1'b0;
		tick(3);
		chk(mode_ff, 3'h0);
		self_prog_req = 1'b0;
	endtask : t_self

	// Runs last; the sticky lock clears only at reset, which do_reset gives each scenario
	task automatic t_wprot();
		do_reset(1'b1);
		opt_write_protect = 1'b1;
		tick(2);
		req(1'b0, 2'h0, 13'h0400, 6'h01, 1'b0, 1'b0);
		req(1'b0, 2'h2, 13'h0000, 6'h01, 1'b1, 1'b0);
		opt_write_protect = 1'b0;
		tick(2);
		req(1'b1, 2'h0, 13'h0400, 6'h01, 1'b0, 1'b0);
	endtask : t_wprot

	task automatic finish_test();
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	initial begin
		{nrst, socket_strap, test_sel, sclk_app_out, sclk_app_oe} = 5'h00;
		{opt_read_protect, opt_write_protect, self_prog_req, pc_in_sec0} = 4'h0;
		{req_valid, req_erase, opt_sec0_size, req_target} = 6'h00;
		req_addr = 13'h0000;
		req_len = 6'h00;
		t_user();
		t_socket();
		t_link(1'b0, 3);
		t_link(1'b1, 1);
		t_self();
		t_wprot();
		finish_test();
	end

	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end
endmodule : pfac_top_tb
`default_nettype wire

// ===== src/pfac_link_rx.sv
// Serial link front end: entry sequence detection and byte reception.
// Assumes link pins are already synchronous to ref_clk and rst_n is synced.
`timescale 1ns/100ps
`default_nettype none
module pfac_link_rx
	import pfac_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       reset_pin_low,
	input  wire logic       test_sel,
	input  wire logic       sclk_in,
	input  wire logic       sdata_in,
	output logic            enter_ff,
	output logic            test_ff,
	output logic            linked_ff,
	output logic            byte_vld_ff,
	output logic [7:0]      byte_ff
);
	logic       sclk_q_ff;
	logic [2:0] pulse_cnt_ff;
	logic [2:0] bit_cnt_ff;
	logic [6:0] shift_ff;
	logic       sclk_rise;

	assign sclk_rise = sclk_in & ~sclk_q_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) sclk_q_ff <= 1'b0;
		else sclk_q_ff <= sclk_in;
	end

	// entry sequence count
	// Clock pulses with data high while reset is held low arm the entry
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_cnt_ff <= 3'h0;
			enter_ff     <= 1'b0;
			test_ff      <= 1'b0;
			linked_ff    <= 1'b0;
		end else begin
			enter_ff <= 1'b0;
			if (reset_pin_low) begin
				linked_ff <= 1'b0;
				if (sclk_rise && sdata_in && pulse_cnt_ff != ENTRY_PULSES)
					pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
			end else if (pulse_cnt_ff == ENTRY_PULSES) begin
				pulse_cnt_ff <= 3'h0;
				enter_ff     <= 1'b1;
				linked_ff    <= 1'b1;
				test_ff      <= test_sel;
			end else begin
				pulse_cnt_ff <= 3'h0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_ff  <= 3'h0;
			shift_ff    <= 7'h00;
			byte_vld_ff <= 1'b0;
			byte_ff     <= 8'h00;
		end else begin
			byte_vld_ff <= 1'b0;
			if (!linked_ff) begin
				bit_cnt_ff <= 3'h0;
			end else if (sclk_rise) begin
				shift_ff   <= {shift_ff[5:0], sdata_in};
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == BIT_LAST) begin
					byte_ff     <= {shift_ff, sdata_in};
					byte_vld_ff <= 1'b1;
				end
			end
		end
	end

	ent_after_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enter_ff |-> $past(pulse_cnt_ff) == ENTRY_PULSES && !$past(reset_pin_low))
		else $error("entry without full sequence");
endmodule : pfac_link_rx
`default_nettype wire

// ===== src/pfac_pkg.sv
// Constants, modes and helpers for the program flash mode access control.
// Assumes one 100 MHz clock and option byte fields already decoded by the caller.
package pfac_pkg;
	localparam int unsigned FLASH_AW       = 13;
	localparam int unsigned RAM_AW         = 9;
	localparam int unsigned LEN_W          = 6;
	localparam logic [5:0]  MAX_GROUP      = 6'h20;
	localparam logic [5:0]  MIN_GROUP      = 6'h01;
	localparam logic [2:0]  ENTRY_PULSES   = 3'h4;
	localparam logic [2:0]  BIT_LAST       = 3'h7;
	localparam logic [8:0]  RAM_LOAD_BASE  = 9'h080;
	localparam logic [1:0]  SYNC_RST_VAL   = 2'h0;

	// Sector 0 size selected by the option byte field, in bytes
	localparam logic [12:0] SEC0_SIZE_0    = 13'h0200;
	localparam logic [12:0] SEC0_SIZE_1    = 13'h0400;
	localparam logic [12:0] SEC0_SIZE_2    = 13'h0800;
	localparam logic [12:0] SEC0_SIZE_3    = 13'h1000;

	typedef enum logic [1:0] {
		PFAC_TGT_FLASH,
		PFAC_TGT_OPTION,
		PFAC_TGT_EEPROM,
		PFAC_TGT_NONE
	} pfac_target_e;

	typedef enum {
		PFAC_USER,
		PFAC_SOCKET,
		PFAC_BOARD,
		PFAC_TEST,
		PFAC_SELF
	} pfac_mode_e;

	function automatic logic [12:0] pfac_sec0_limit(input logic [1:0] sel);
		logic [12:0] lim;
		lim = SEC0_SIZE_0;
		unique case (sel)
			2'h0: lim = SEC0_SIZE_0;
			2'h1: lim = SEC0_SIZE_1;
			2'h2: lim = SEC0_SIZE_2;
			2'h3: lim = SEC0_SIZE_3;
		endcase
		return lim;
	endfunction : pfac_sec0_limit
endpackage : pfac_pkg

// ===== src/pfac_top.sv
// Program flash mode access control: mode tracking, request filtering, driver load.
// Assumes option byte fields are stable and link pins are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module pfac_top
	import pfac_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	input  wire logic                socket_strap,
	input  wire logic                reset_pin_low,
	input  wire logic                test_sel,
	input  wire logic                sclk_in,
	input  wire logic                sdata_in,
	input  wire logic                sclk_app_out,
	input  wire logic                sclk_app_oe,
	input  wire logic [1:0]          opt_sec0_size,
	input  wire logic                opt_read_protect,
	input  wire logic                opt_write_protect,
	input  wire logic                self_prog_req,
	input  wire logic                pc_in_sec0,
	input  wire logic                req_valid,
	input  wire logic                req_erase,
	input  wire logic [1:0]          req_target,
	input  wire logic [FLASH_AW-1:0] req_addr,
	input  wire logic [LEN_W-1:0]    req_len,
	output logic                     op_go_ff,
	output logic                     op_erase_ff,
	output logic [1:0]               op_target_ff,
	output logic                     op_sector_ff,
	output logic [FLASH_AW-1:0]      op_addr_ff,
	output logic [LEN_W-1:0]         op_len_ff,
	output logic                     op_reject_ff,
	output logic [2:0]               mode_ff,
	output logic                     boot_sys_vec_ff,
	output logic                     ram_we_ff,
	output logic [RAM_AW-1:0]        ram_addr_ff,
	output logic [7:0]               ram_data_ff,
	output logic                     ram_exec_ff,
	output logic                     read_block_ff,
	output logic                     sclk_out_ff,
	output logic                     sclk_oe_ff,
	output logic                     sclk_pullup_ff
);
	logic [1:0]  rst_sync_ff;
	logic        rst_n;
	pfac_mode_e  state_ff;
	logic        strap_seen_ff;
	logic        wp_lock_ff;
	logic [7:0]  load_left_ff;
	logic        len_phase_ff;
	logic        enter;
	logic        link_test;
	logic        linked;
	logic        byte_vld;
	logic [7:0]  rx_byte;
	logic        nxt_ok;
	logic        nxt_sector;
	logic        len_ok;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) rst_sync_ff <= SYNC_RST_VAL;
		else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	pfac_link_rx u_link (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.reset_pin_low (reset_pin_low),
		.test_sel      (test_sel),
		.sclk_in       (sclk_in),
		.sdata_in      (sdata_in),
		.enter_ff      (enter),
		.test_ff       (link_test),
		.linked_ff     (linked),
		.byte_vld_ff   (byte_vld),
		.byte_ff       (rx_byte)
	);

	// Permission by mode, target and sector; the core of the filter
	function automatic logic pfac_allowed(input pfac_mode_e m, input logic [1:0] tgt,
		input logic sec1);
		logic ok;
		ok = 1'b0;
		unique case (m)
			PFAC_SOCKET, PFAC_BOARD: ok = (tgt != PFAC_TGT_NONE);
			PFAC_SELF:               ok = (tgt == PFAC_TGT_EEPROM) ||
				(tgt == PFAC_TGT_FLASH && sec1);
			PFAC_USER, PFAC_TEST:    ok = 1'b0;
		endcase
		return ok;
	endfunction : pfac_allowed

	assign nxt_sector = (req_addr >= pfac_sec0_limit(opt_sec0_size));
	assign len_ok = (req_len >= MIN_GROUP) && (req_len <= MAX_GROUP);
	// mode gate
	// Protections only cover the program array; option row stays writable to lift ROP
	assign nxt_ok = len_ok && pfac_allowed(state_ff, req_target, nxt_sector) &&
		!(req_target == PFAC_TGT_FLASH && (opt_read_protect || wp_lock_ff));

	// Socket strap is caught once, after reset release, never under reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff      <= PFAC_USER;
			strap_seen_ff <= 1'b0;
		end else begin
			strap_seen_ff <= 1'b1;
			if (!strap_seen_ff && socket_strap) begin
				state_ff <= PFAC_SOCKET;
			end else if (enter) begin
				state_ff <= link_test ? PFAC_TEST : PFAC_BOARD;
			end else begin
				unique case (state_ff)
					PFAC_USER: if (self_prog_req && pc_in_sec0) state_ff <= PFAC_SELF;
					PFAC_SELF: if (!self_prog_req || !pc_in_sec0) state_ff <= PFAC_USER;
					PFAC_BOARD, PFAC_TEST: if (reset_pin_low) state_ff <= PFAC_USER;
					PFAC_SOCKET: state_ff <= PFAC_SOCKET;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) mode_ff <= 3'h0;
		else mode_ff <= 3'(state_ff);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) wp_lock_ff <= 1'b0;
		else if (opt_write_protect) wp_lock_ff <= 1'b1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_go_ff     <= 1'b0;
			op_reject_ff <= 1'b0;
			op_erase_ff  <= 1'b0;
			op_target_ff <= 2'h0;
			op_sector_ff <= 1'b0;
			op_addr_ff   <= '0;
			op_len_ff    <= '0;
		end else begin
			op_go_ff     <= req_valid && nxt_ok;
			op_reject_ff <= req_valid && !nxt_ok;
			if (req_valid && nxt_ok) begin
				op_erase_ff  <= req_erase;
				op_target_ff <= req_target;
				op_sector_ff <= nxt_sector;
				op_addr_ff   <= req_addr;
				op_len_ff    <= req_len;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) boot_sys_vec_ff <= 1'b0;
		else if (enter) boot_sys_vec_ff <= 1'b1;
		else if (!linked) boot_sys_vec_ff <= 1'b0;
	end

	// driver load then run
	// First link byte gives the byte count; RAM runs from the cycle the last byte's write strobe rises
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ram_we_ff    <= 1'b0;
			ram_addr_ff  <= RAM_LOAD_BASE;
			ram_data_ff  <= 8'h00;
			ram_exec_ff  <= 1'b0;
			load_left_ff <= 8'h00;
			len_phase_ff <= 1'b0;
		end else begin
			ram_we_ff <= 1'b0;
			if (enter) begin
				ram_addr_ff  <= RAM_LOAD_BASE;
				ram_exec_ff  <= 1'b0;
				len_phase_ff <= 1'b1;
			end else if (!linked) begin
				ram_exec_ff  <= 1'b0;
				len_phase_ff <= 1'b0;
			end else if (byte_vld && len_phase_ff) begin
				load_left_ff <= rx_byte;
				len_phase_ff <= 1'b0;
				ram_exec_ff  <= (rx_byte == 8'h00);
			end else if (byte_vld && !ram_exec_ff) begin
				ram_we_ff    <= 1'b1;
				ram_data_ff  <= rx_byte;
				// Step past a write still in flight so no address is reused
				if (ram_we_ff) ram_addr_ff <= ram_addr_ff + 9'h001;
				load_left_ff <= load_left_ff - 8'h01;
				ram_exec_ff  <= (load_left_ff == 8'h01);
			end else if (ram_we_ff) begin
				ram_addr_ff <= ram_addr_ff + 9'h001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) read_block_ff <= 1'b1;
		else read_block_ff <= opt_read_protect && (state_ff != PFAC_USER) &&
			(state_ff != PFAC_SELF);
	end

	// pin back to input
	// Pulled up from reset on unless sclk_app_oe drives it while unlinked, so a noisy pin cannot slip into link entry
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_oe_ff     <= 1'b0;
			sclk_out_ff    <= 1'b0;
			sclk_pullup_ff <= 1'b1;
		end else begin
			sclk_oe_ff     <= sclk_app_oe && !linked;
			sclk_out_ff    <= sclk_app_out;
			sclk_pullup_ff <= !(sclk_app_oe && !linked);
		end
	end

	self_sec0_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_go_ff && $past(state_ff) == PFAC_SELF |-> op_sector_ff || op_target_ff == 2'h2)
		else $error("sector 0 changed in self mode");
	group_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op_go_ff |-> op_len_ff >= MIN_GROUP && op_len_ff <= MAX_GROUP)
		else $error("group length out of range");
	bad_req_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req_valid && !pfac_allowed(state_ff, req_target, nxt_sector) |=> op_reject_ff && !op_go_ff)
		else $error("forbidden request not ignored");
	user_none_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(state_ff) == PFAC_USER |-> !op_go_ff)
		else $error("write granted in user mode");
	rop_flash_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req_valid && opt_read_protect && req_target == 2'h0 |=> !op_go_ff)
		else $error("flash write under read-out protection");
	wp_forever_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wp_lock_ff |=> wp_lock_ff ##1 wp_lock_ff)
		else $error("write lock cleared");
	sec0_size_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req_valid && nxt_ok && req_target == 2'h0 |=>
		op_sector_ff == (op_addr_ff >= pfac_sec0_limit($past(opt_sec0_size))))
		else $error("sector split mismatch");
	entry_vec_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enter |=> boot_sys_vec_ff && (state_ff == PFAC_BOARD || state_ff == PFAC_TEST))
		else $error("entry without system vector");
	pin_input_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> !sclk_oe_ff && sclk_pullup_ff)
		else $error("clock pin not input after reset");
	board_all_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req_valid && state_ff == PFAC_BOARD && len_ok &&
		(req_target == 2'h1 || req_target == 2'h2) |=> op_go_ff)
		else $error("board mode refused permitted region");

	self_ok_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		state_ff == PFAC_SELF && req_valid && nxt_ok);
	load_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(ram_exec_ff));
	test_in_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		enter && link_test);
	rej_c: cover property (@(posedge ref_clk) disable iff (!rst_n) op_reject_ff);
endmodule : pfac_top
`default_nettype wire
